/* File: csi_checker.sv */
// Pin-level assertions for the serial shift port
`timescale 1ns/100ps
`include "csi_consts.svh"

module csi_checker (
  // Clock and reset
  input wire logic                   ref_clk,
  input wire logic                   resetn,
  // Controls
  input wire logic                   port_enable_bit,
  input wire logic                   transmit_mode_bit,
  input wire logic                   data_phase_select,
  input wire logic                   bit_order_select,
  input wire logic                   tx_write,
  input wire logic [`CSI_DATA_W-1:0] tx_data,
  input wire logic                   rx_read,
  input wire logic                   flag_clear,
  // Outputs
  input wire logic [`CSI_DATA_W-1:0] transmit_buffer,
  input wire logic [`CSI_DATA_W-1:0] shift_register,
  input wire logic                   transfer_busy_flag,
  input wire logic                   completion_interrupt_flag,
  input wire logic                   completion_interrupt,
  input wire logic                   serial_out_line
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  wire logic dis_val = transmit_mode_bit & data_phase_select &
    (bit_order_select ? transmit_buffer[0] : transmit_buffer[7]);
  wire logic start = port_enable_bit & ~transfer_busy_flag &
    (tx_write & transmit_mode_bit | rx_read & ~transmit_mode_bit);
  wire logic idle = port_enable_bit & ~transfer_busy_flag & ~tx_write &
    ~rx_read;

  property p_start_busy;
    start |=> transfer_busy_flag;
  endproperty
  a_start_busy: assert property (p_start_busy)
    else $error("busy not raised by start");
  property p_tx_load;
    tx_write && !transfer_busy_flag |=> transmit_buffer == $past(tx_data);
  endproperty
  a_tx_load: assert property (p_tx_load)
    else $error("buffer not loaded");
  property p_irq_pulse;
    completion_interrupt |=> !completion_interrupt;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse)
    else $error("completion pulse too long");
  property p_irq_flag;
    completion_interrupt |->
      ##[0:1] (completion_interrupt_flag && !transfer_busy_flag);
  endproperty
  a_irq_flag: assert property (p_irq_flag)
    else $error("flag or busy wrong at completion");
  property p_flag_sticky;
    completion_interrupt_flag && !flag_clear |=> completion_interrupt_flag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("flag dropped");
  property p_off_reset;
    !port_enable_bit |-> !transfer_busy_flag && shift_register == 8'h00;
  endproperty
  a_off_reset: assert property (p_off_reset)
    else $error("disable did not clear core");
  property p_off_out;
    !port_enable_bit && $past(!port_enable_bit) |->
      serial_out_line == $past(dis_val);
  endproperty
  a_off_out: assert property (p_off_out)
    else $error("disabled output level wrong");
  // Idle for three cycles lets the registered pin settle first
  property p_hold_last;
    (idle && $stable({transmit_mode_bit, data_phase_select,
      bit_order_select}))[*3] |=> $stable(serial_out_line);
  endproperty
  a_hold_last: assert property (p_hold_last)
    else $error("output moved while idle");
endmodule : csi_checker

/* File: csi_consts.svh */
// Constants of the clocked serial shift port: widths, bit positions, counts
`ifndef CSI_SHIFT_PORT_CONSTS_SVH
`define CSI_SHIFT_PORT_CONSTS_SVH

// ----------------------------------------------------------------------------
// Data unit
// ----------------------------------------------------------------------------
`define CSI_DATA_W       8
`define CSI_MSB_POS      7
`define CSI_LSB_POS      0
`define CSI_CNT_W        3
`define CSI_CNT_ZERO     3'h0
`define CSI_CNT_ONE      3'h1
`define CSI_CNT_LAST     3'h7

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define CSI_BYTE_RST     8'h00
`define CSI_BIT_RST      1'b0
`define CSI_SYNC_RST     2'h0
`define CSI_RST_DONE     2'h3
`define CSI_SYNC_LAST    1
`define CSI_ARM_W        3
`define CSI_ARM_RST      3'h0

`endif

/* File: csi_master_model.sv */
// Clocked serial master driving the port's link pins
`timescale 1ns/100ps

module csi_master_model (
  // Link pins
  output logic      shift_clock_line,
  output logic      serial_in_line,
  input  wire logic serial_out_line
);
  initial begin
    shift_clock_line = 1'b1;
    serial_in_line   = 1'b0;
  end

  // One byte each way, 320 ns per bit; clock stands still between frames
  task automatic frame(input logic pol, dap, ord, input logic [7:0] d,
                       output logic [7:0] q);
    logic [7:0] s;
    logic       b;
    s = d;
    q = 8'h00;
    b = 1'b0;
    serial_in_line = ord ? s[0] : s[7];
    #160;
    for (int k = 0; k < 8; k++) begin
      shift_clock_line = pol;
      serial_in_line = ord ? s[0] : s[7];
      #150;
      if (dap)
        b = serial_out_line;
      #10;
      shift_clock_line = !pol;
      s = ord ? s >> 1 : s << 1;
      if (dap)
        serial_in_line = ord ? s[0] : s[7];
      #150;
      if (!dap)
        b = serial_out_line;
      q = ord ? {b, q[7:1]} : {q[6:0], b};
      #10;
    end
    // Released line shows the inverse so a stale bit cannot pass
    serial_in_line = !serial_in_line;
  endtask : frame
endmodule : csi_master_model

/* File: csi_pkg.sv */
// Types shared by the clocked serial shift port
package csi_pkg;

  // --------------------------------------------------------------------------
  // Transfer sequencing
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    XFER_IDLE  = 2'b00,
    XFER_FIRST = 2'b01,
    XFER_SHIFT = 2'b10
  } xfer_state_e;

endpackage : csi_pkg

/* File: csi_shift_port.sv */
// Eight-bit three-wire clocked serial shift port, slave clocked
//
// Behaviour
// - Phase 0: the first leading clock edge puts buffer bit one out.
// - Phase 0: the next trailing edge loads, shifts and captures input.
// - Phase 0: later leading edges put shift register bits out.
// - Phase 1: the start strobe itself puts buffer bit one out.
// - Phase 1: the first leading edge loads, shifts and captures input.
// - Phase 1: later trailing edges put shift register bits out.
// - After a transfer the output keeps the last transmitted bit.
// - Disabled: output low in receive mode, latch (low) in phase 0.
// - Disabled, transmit, phase 1: output is buffer bit 7 or bit 0.
// - Mode writes, and phase and order writes while disabled, change the output level on the next ref_clk edge.
// - Data moves in 8-bit units, one bit per serial clock.
// - Buffer write in transmit mode or shift read in receive starts.
// - Busy rises at start; after 8 bits done flag set and busy clear.
// - Clearing the enable resets busy, shift register and sequencing.
`timescale 1ns/100ps
`include "csi_consts.svh"

module csi_shift_port (
  // Clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    resetn,
  // Configuration bits
  input  wire logic                    port_enable_bit,
  input  wire logic                    transmit_mode_bit,
  input  wire logic                    data_phase_select,
  input  wire logic                    bit_order_select,
  input  wire logic                    clock_polarity_bit,
  // Software data access
  input  wire logic                    tx_write,
  input  wire logic [`CSI_DATA_W-1:0]  tx_data,
  input  wire logic                    rx_read,
  output logic      [`CSI_DATA_W-1:0]  transmit_buffer,
  output logic      [`CSI_DATA_W-1:0]  shift_register,
  // Status
  output logic                         transfer_busy_flag,
  output logic                         completion_interrupt_flag,
  input  wire logic                    flag_clear,
  output logic                         completion_interrupt,
  // Serial pins
  input  wire logic                    shift_clock_line,
  input  wire logic                    serial_in_line,
  output logic                         serial_out_line
);

  // --------------------------------------------------------------------------
  // Reset release
  // --------------------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic       rst_n;
  logic       core_rst_n;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_q <= `CSI_SYNC_RST;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  // Last stage only: a decode of both stages could glitch the async reset
  assign rst_n = rst_sync_q[`CSI_SYNC_LAST];

  // The enable acts as an asynchronous clear of the transfer core
  assign core_rst_n = rst_n & port_enable_bit;

  // --------------------------------------------------------------------------
  // Pin sampling and edge finding
  // --------------------------------------------------------------------------
  logic [1:0] pins_s;
  logic       sck_s;
  logic       si_s;
  logic       sck_prev_q;
  logic [`CSI_ARM_W-1:0] arm_q;
  logic       sck_armed;

  csi_sync2 u_sync (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .async_in ({shift_clock_line, serial_in_line}),
    .sync_out (pins_s)
  );

  assign sck_s = pins_s[1];
  assign si_s  = pins_s[0];

  // Edges count only once the pin copy and its previous value are both
  // real; else an idle-high clock reads as a rise just after reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_prev_q <= `CSI_BIT_RST;
      arm_q      <= `CSI_ARM_RST;
    end else begin
      sck_prev_q <= sck_s;
      arm_q      <= {arm_q[`CSI_ARM_W-2:0], 1'b1};
    end
  end

  assign sck_armed = arm_q[`CSI_ARM_W-1];

  wire sck_rise = sck_armed & sck_s & ~sck_prev_q;
  wire sck_fall = sck_armed & ~sck_s & sck_prev_q;

  // Leading edge is falling at polarity 0, rising at polarity 1
  wire lead_edge  = clock_polarity_bit ? sck_rise : sck_fall;
  wire trail_edge = clock_polarity_bit ? sck_fall : sck_rise;

  // Phase 0 captures on trailing edges, phase 1 on leading edges
  wire capture_edge = data_phase_select ? lead_edge : trail_edge;
  wire output_edge  = data_phase_select ? trail_edge : lead_edge;

  // --------------------------------------------------------------------------
  // Transfer start
  // --------------------------------------------------------------------------
  logic busy_q;
  logic busy_d;

  // A strobe while busy is dropped; software is expected not to do it
  wire access_ok = port_enable_bit & ~busy_q;
  wire start_tx  = tx_write & transmit_mode_bit;
  wire start_rx  = rx_read & ~transmit_mode_bit;
  wire start_xfer = access_ok & (start_tx | start_rx);

  // --------------------------------------------------------------------------
  // Transmit buffer
  // --------------------------------------------------------------------------
  logic [`CSI_DATA_W-1:0] tx_buf_q;
  logic [`CSI_DATA_W-1:0] tx_buf_d;

  // Kept across disable: the disabled output may show one of its bits
  assign tx_buf_d = (tx_write & ~busy_q) ? tx_data : tx_buf_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_buf_q <= `CSI_BYTE_RST;
    end else begin
      tx_buf_q <= tx_buf_d;
    end
  end

  // --------------------------------------------------------------------------
  // Sequencing
  // --------------------------------------------------------------------------
  csi_pkg::xfer_state_e       state_q;
  csi_pkg::xfer_state_e       state_d;
  logic [`CSI_CNT_W-1:0]      cnt_q;
  logic [`CSI_CNT_W-1:0]      cnt_d;

  wire in_first = (state_q == csi_pkg::XFER_FIRST);
  wire in_shift = (state_q == csi_pkg::XFER_SHIFT);
  wire last_bit = (cnt_q == `CSI_CNT_LAST);
  wire done     = in_shift & capture_edge & last_bit;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      csi_pkg::XFER_IDLE: begin
        if (start_xfer) begin
          state_d = csi_pkg::XFER_FIRST;
          cnt_d   = `CSI_CNT_ZERO;
        end
      end
      csi_pkg::XFER_FIRST: begin
        if (capture_edge) begin
          state_d = csi_pkg::XFER_SHIFT;
          cnt_d   = `CSI_CNT_ONE;
        end
      end
      csi_pkg::XFER_SHIFT: begin
        if (capture_edge) begin
          if (last_bit) begin
            state_d = csi_pkg::XFER_IDLE;
          end else begin
            cnt_d = cnt_q + `CSI_CNT_ONE;
          end
        end
      end
      default: begin
        state_d = csi_pkg::XFER_IDLE;
        cnt_d   = `CSI_CNT_ZERO;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      state_q <= csi_pkg::XFER_IDLE;
      cnt_q   <= `CSI_CNT_ZERO;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  // --------------------------------------------------------------------------
  // Busy and completion
  // --------------------------------------------------------------------------
  logic flag_q;
  logic flag_d;
  logic irq_q;

  assign busy_d = start_xfer ? 1'b1 : (done ? 1'b0 : busy_q);

  always_ff @(posedge ref_clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      busy_q <= `CSI_BIT_RST;
    end else begin
      busy_q <= busy_d;
    end
  end

  // Set wins over a clear in the same cycle
  assign flag_d = done | (flag_q & ~flag_clear);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= `CSI_BIT_RST;
      irq_q  <= `CSI_BIT_RST;
    end else begin
      flag_q <= flag_d;
      irq_q  <= done;
    end
  end

  // --------------------------------------------------------------------------
  // Shift register
  // --------------------------------------------------------------------------
  logic [`CSI_DATA_W-1:0] sr_q;
  logic [`CSI_DATA_W-1:0] sr_d;

  // First capture loads from the buffer, later ones shift in place
  wire [`CSI_DATA_W-1:0] shift_src = in_first ? tx_buf_q : sr_q;
  wire [`CSI_DATA_W-1:0] shift_lsb =
    {si_s, shift_src[`CSI_MSB_POS:`CSI_LSB_POS+1]};
  wire [`CSI_DATA_W-1:0] shift_msb =
    {shift_src[`CSI_MSB_POS-1:`CSI_LSB_POS], si_s};
  wire [`CSI_DATA_W-1:0] shifted = bit_order_select ? shift_lsb : shift_msb;

  wire do_capture = (in_first | in_shift) & capture_edge;

  assign sr_d = do_capture ? shifted : sr_q;

  always_ff @(posedge ref_clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      sr_q <= `CSI_BYTE_RST;
    end else begin
      sr_q <= sr_d;
    end
  end

  // --------------------------------------------------------------------------
  // Output latch
  // --------------------------------------------------------------------------
  logic latch_q;
  logic latch_d;

  wire new_first = bit_order_select ? tx_data[`CSI_LSB_POS]
                                    : tx_data[`CSI_MSB_POS];
  wire buf_first = bit_order_select ? tx_buf_q[`CSI_LSB_POS]
                                    : tx_buf_q[`CSI_MSB_POS];
  wire sr_next   = bit_order_select ? sr_q[`CSI_LSB_POS]
                                    : sr_q[`CSI_MSB_POS];

  // Phase 1 strobe takes the fresh write data straight from the port
  wire load_strobe = start_xfer & data_phase_select;
  wire load_first  = in_first & output_edge & ~data_phase_select;
  // Phase 0 later bits on leading edges, phase 1 on trailing edges
  wire load_next   = in_shift & output_edge;

  // No load after the last capture, so the last bit stays put
  assign latch_d = load_strobe ? new_first :
                   load_first  ? buf_first :
                   load_next   ? sr_next   : latch_q;

  always_ff @(posedge ref_clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      latch_q <= `CSI_BIT_RST;
    end else begin
      latch_q <= latch_d;
    end
  end

  // --------------------------------------------------------------------------
  // Output selector
  // --------------------------------------------------------------------------
  logic so_q;
  logic so_d;

  wire disabled_buf = ~port_enable_bit & data_phase_select;
  wire buf_edge_bit = bit_order_select ? tx_buf_q[`CSI_LSB_POS]
                                       : tx_buf_q[`CSI_MSB_POS];

  // Decoded every cycle from the mode bits, so a write shows on the next ref_clk edge
  assign so_d = ~transmit_mode_bit ? 1'b0 :
                disabled_buf       ? buf_edge_bit :
                latch_q;

  // Not cleared by the enable: the disabled level must still be driven
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      so_q <= `CSI_BIT_RST;
    end else begin
      so_q <= so_d;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign serial_out_line           = so_q;
  assign transmit_buffer           = tx_buf_q;
  assign shift_register            = sr_q;
  assign transfer_busy_flag        = busy_q;
  assign completion_interrupt_flag = flag_q;
  assign completion_interrupt      = irq_q;

endmodule : csi_shift_port

/* File: csi_sync2.sv */
// Two-flop synchroniser for the serial clock and serial input pins
`timescale 1ns/100ps
`include "csi_consts.svh"

module csi_sync2 (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // Asynchronous pins
  input  wire logic [1:0] async_in,
  // Synchronised copies
  output logic      [1:0] sync_out
);

  logic [1:0] meta_q;
  logic [1:0] stable_q;

  // Only the second stage is ever read downstream
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q   <= `CSI_SYNC_RST;
      stable_q <= `CSI_SYNC_RST;
    end else begin
      meta_q   <= async_in;
      stable_q <= meta_q;
    end
  end

  assign sync_out = stable_q;

endmodule : csi_sync2

/* File: tb.sv */
// Self-checking bench for the serial shift port
`timescale 1ns/100ps

module tb;
  logic       ref_clk = 1'b0;
  logic       resetn  = 1'b0;
  logic       en = 1'b0, tm = 1'b0, dap = 1'b0, ord = 1'b0, pol = 1'b0;
  logic       txw = 1'b0, rxr = 1'b0, fclr = 1'b0;
  logic [7:0] txd = 8'h00, got, tbuf, sreg;
  logic       busy, flag, irq, sck, si, so;
  int         error_cnt = 0, total_checks = 0, cyc = 0, irqs = 0;
  // Row: {polarity, phase, order, transmit}, byte sent, byte received
  typedef struct packed {logic [3:0] c; logic [7:0] tx, rx;} row_s;
  row_s       rows [8] = '{20'h155aa, 20'h5a35c, 20'h93cc3, 20'hd817e,
                           20'h312e4, 20'hff00f, 20'h4a596, 20'ha0069};

  always #20 ref_clk = ~ref_clk;

  csi_shift_port csi_shift_port_i (
    .ref_clk, .resetn, .port_enable_bit(en), .transmit_mode_bit(tm),
    .data_phase_select(dap), .bit_order_select(ord),
    .clock_polarity_bit(pol), .tx_write(txw), .tx_data(txd),
    .rx_read(rxr), .transmit_buffer(tbuf), .shift_register(sreg),
    .transfer_busy_flag(busy), .completion_interrupt_flag(flag),
    .flag_clear(fclr), .completion_interrupt(irq),
    .shift_clock_line(sck), .serial_in_line(si), .serial_out_line(so));
  csi_master_model csi_master_model_i (.shift_clock_line(sck),
    .serial_in_line(si), .serial_out_line(so));

  task automatic chk(input logic ok, input string msg);
    total_checks++;
    if (!ok) begin
      error_cnt++;
      $display("Error at %0t ns: %s", $time, msg);
    end
  endtask : chk
  task automatic cfg(input logic [4:0] c);
    @(posedge ref_clk);
    {pol, dap, ord, tm, en} <= c;
    fclr <= 1'b1;
    @(posedge ref_clk);
    fclr <= 1'b0;
  endtask : cfg
  task automatic strobe(input logic rd, input logic [7:0] d);
    @(posedge ref_clk);
    txw <= !rd;
    rxr <= rd;
    txd <= d;
    @(posedge ref_clk);
    txw <= 1'b0;
    rxr <= 1'b0;
    @(negedge ref_clk);
  endtask : strobe
  task automatic results();
    if (error_cnt == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (irq === 1'b1)
      irqs <= irqs + 1;
    if (cyc == 4000) begin
      error_cnt++;
      results();
    end
  end

  initial begin
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (3) @(negedge ref_clk);
    chk(busy === 1'b0 && so === 1'b0 && tbuf === 8'h00, "reset state");
    foreach (rows[i]) begin
      cfg({rows[i].c, 1'b0});
      csi_master_model_i.shift_clock_line = !rows[i].c[3];
      cfg({rows[i].c, 1'b1});
      strobe(!rows[i].c[0], rows[i].tx);
      @(negedge ref_clk);
      chk(busy === 1'b1 && flag === 1'b0, "busy or flag");
      csi_master_model_i.frame(rows[i].c[3], rows[i].c[2], rows[i].c[1],
                               rows[i].rx, got);
      for (int k = 0; k < 40 && busy !== 1'b0; k++)
        @(negedge ref_clk);
      repeat (2) @(negedge ref_clk);
      chk(sreg === rows[i].rx, "received byte");
      chk(flag === 1'b1 && irqs == i + 1, "completion");
      if (rows[i].c[0]) begin
        chk(got === rows[i].tx,
            "sent byte");
        chk(so === (rows[i].c[1] ? rows[i].tx[7] : rows[i].tx[0]),
            "last bit");
      end
    end
    // Disabled pin levels for every mode, phase and order
    for (int c = 0; c < 8; c++) begin
      cfg({1'b0, c[2:0], 1'b0});
      strobe(1'b0, 8'h01);
      @(negedge ref_clk);
      chk(so === (c == 7), "disabled level");
    end
    // Strobe refused mid-transfer, then the port is switched off
    csi_master_model_i.shift_clock_line = 1'b1;
    cfg(5'b00011);
    strobe(1'b0, 8'ha5);
    fork
      csi_master_model_i.frame(1'b0, 1'b0, 1'b0, 8'h5a, got);
    join_none
    repeat (30) @(posedge ref_clk);
    strobe(1'b0, 8'h3c);
    chk(tbuf === 8'ha5 && busy === 1'b1, "strobe while busy");
    @(posedge ref_clk);
    en <= 1'b0;
    @(negedge ref_clk);
    chk(busy === 1'b0 && sreg === 8'h00, "disable clear");
    repeat (70) @(posedge ref_clk);
    chk(irqs == 8, "completion after abort");
    // Mid-run reset; the first start lands on the third edge after release,
    // while the idle-high clock is still settling through the sampler
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    en     <= 1'b1;
    @(posedge ref_clk);
    strobe(1'b0, 8'h96);
    chk(busy === 1'b1 && flag === 1'b0 && tbuf === 8'h96,
        "start after reset");
    csi_master_model_i.frame(1'b0, 1'b0, 1'b0, 8'h3c, got);
    repeat (8) @(negedge ref_clk);
    chk(sreg === 8'h3c && got === 8'h96 && irqs == 9,
        "transfer after reset");
    results();
  end
endmodule : tb

bind csi_shift_port csi_checker csi_checker_i (
  .ref_clk, .resetn, .port_enable_bit, .transmit_mode_bit,
  .data_phase_select, .bit_order_select, .tx_write, .tx_data, .rx_read,
  .flag_clear, .transmit_buffer, .shift_register, .transfer_busy_flag,
  .completion_interrupt_flag, .completion_interrupt, .serial_out_line);
